// ===== core/pcmsf_port.sv
// Short-frame PCM audio port with AHB-Lite register access.
// Assumes hclk at 100 MHz; link pins are asynchronous to hclk.
//
// Functional notes
// - Short-frame sync is the only framing
// - Port runs as timing master or slave
// - Sample on falling, launch on rising
// - Sync falling edge marks sample MSB
// - 8 kHz frames at 256k to 2048k
// - Near-16 kHz frames with 4069k bit clock
// - Samples are 16-bit linear, uncompanded
// - Master drives clock/sync; slave only listens
// - Rate and role set by software
// - Defaults: master, 2048k clock, 8k sync
`timescale 1ns/100ps
module pcmsf_port
(
  // System clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Bit clock pin
  input wire logic bclk_in,
  output logic bclk_out,
  output logic bclk_oe,
  // Frame sync pin
  input wire logic fsync_in,
  output logic fsync_out,
  output logic fsync_oe,
  // Serial data
  input wire logic din,
  output logic dout
);

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic ctrl_en; // Port enable
  logic ctrl_master; // Timing role
  pcmsf_pkg::pcmsf_rate_t ctrl_rate; // Bit clock selection
  logic [15:0] tx_data; // Next sample to send
  logic [15:0] rx_data; // Last sample received
  logic rx_valid; // Sticky: new sample in rx_data
  logic tx_empty; // Sticky: tx_data taken by a frame
  logic overrun; // Sticky: rx_data lost unread
  logic [15:0] tx_word; // Sample being sent
  logic [15:0] rx_shift; // Sample being received
  logic [7:0] pos; // Bit period within frame
  logic [7:0] next_pos;
  logic sync_cap; // Sync seen at last falling edge
  logic [pcmsf_pkg::NCO_W-1:0] nco_acc; // Bit clock phase
  logic [pcmsf_pkg::NCO_W-1:0] nco_inc;
  logic [pcmsf_pkg::NCO_W:0] nco_sum;
  logic [7:0] frame_last; // Last position of a master frame
  // Pin synchronisers and filtered levels
  logic [2:0] bclk_sy;
  logic [2:0] fsync_sy;
  logic [2:0] din_sy;
  logic bclk_lvl;
  logic fsync_lvl;
  logic din_lvl;
  logic rise_ev; // Bit clock rising edge this cycle
  logic fall_ev; // Bit clock falling edge this cycle
  // AHB data-phase capture
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] next_rdata;
  logic rd_rx; // Read of RXDATA accepted
  logic wr_tx; // Write of TXDATA in data phase
  logic addr_ok;
  logic acc; // Transfer accepted this cycle
  logic rd_stat; // Read of STATUS accepted
  logic leave_master; // CTRL write that ends master timing

  // ----------------------------------------
  // Rate tables
  // ----------------------------------------
  // Accumulator step toggles the clock at twice the bit rate
  // and supported rate steps
  always_comb
  begin
    case (ctrl_rate)
      pcmsf_pkg::PCMSF_R256K:
      begin
        nco_inc = 24'((2 * pcmsf_pkg::BCLK_256K_HZ << pcmsf_pkg::NCO_W) / pcmsf_pkg::CLK_HZ);
        frame_last = 8'h1F;
      end
      pcmsf_pkg::PCMSF_R512K:
      begin
        nco_inc = 24'((2 * pcmsf_pkg::BCLK_512K_HZ << pcmsf_pkg::NCO_W) / pcmsf_pkg::CLK_HZ);
        frame_last = 8'h3F;
      end
      pcmsf_pkg::PCMSF_R1024K:
      begin
        nco_inc = 24'((2 * pcmsf_pkg::BCLK_1024K_HZ << pcmsf_pkg::NCO_W) / pcmsf_pkg::CLK_HZ);
        frame_last = 8'h7F;
      end
      pcmsf_pkg::PCMSF_R4069K:
      begin
        // Near-16 kHz frames: 256 periods; 4069k / 16k rounds to 254
        nco_inc = 24'((2 * pcmsf_pkg::BCLK_4069K_HZ << pcmsf_pkg::NCO_W) / pcmsf_pkg::CLK_HZ);
        frame_last = 8'hFF;
      end
      default:
      begin
        nco_inc = 24'((2 * pcmsf_pkg::BCLK_2048K_HZ << pcmsf_pkg::NCO_W) / pcmsf_pkg::CLK_HZ);
        frame_last = 8'hFF;
      end
    endcase
  end

  // ----------------------------------------
  // Pin input synchronisers
  // ----------------------------------------
  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bclk_sy <= 3'h0;
      fsync_sy <= 3'h0;
      din_sy <= 3'h0;
    end
    else
    begin
      bclk_sy <= {bclk_sy[1:0], bclk_in};
      fsync_sy <= {fsync_sy[1:0], fsync_in};
      din_sy <= {din_sy[1:0], din};
    end
  end

  // Filtered levels, updated only on agreement
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bclk_lvl <= 1'b0;
      fsync_lvl <= 1'b0;
      din_lvl <= 1'b0;
    end
    else
    begin
      if (bclk_sy[1] == bclk_sy[2])
        bclk_lvl <= bclk_sy[2];
      if (fsync_sy[1] == fsync_sy[2])
        fsync_lvl <= fsync_sy[2];
      if (din_sy[1] == din_sy[2])
        din_lvl <= din_sy[2];
    end
  end

  // ----------------------------------------
  // Bit clock generation and edge events
  // ----------------------------------------
  assign nco_sum = {1'b0, nco_acc} + {1'b0, nco_inc};

  // Fractional divider: mean rates within one 24-bit step, without a faster clock
  // master generates, slave follows the pin
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      nco_acc <= '0;
      bclk_out <= 1'b0;
    end
    else if (ctrl_en && ctrl_master)
    begin
      nco_acc <= nco_sum[pcmsf_pkg::NCO_W-1:0];
      if (nco_sum[pcmsf_pkg::NCO_W])
        bclk_out <= ~bclk_out;
    end
    else
    begin
      nco_acc <= '0;
      bclk_out <= 1'b0;
    end
  end

  // Edge events from our own clock or the filtered pin
  always_comb
  begin
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    if (ctrl_en && ctrl_master)
    begin
      rise_ev = nco_sum[pcmsf_pkg::NCO_W] && !bclk_out;
      fall_ev = nco_sum[pcmsf_pkg::NCO_W] && bclk_out;
    end
    else if (ctrl_en && (bclk_sy[1] == bclk_sy[2]))
    begin
      rise_ev = bclk_sy[2] && !bclk_lvl;
      fall_ev = !bclk_sy[2] && bclk_lvl;
    end
  end

  // pins driven only in master role
  assign bclk_oe = ctrl_master;
  assign fsync_oe = ctrl_master;

  // ----------------------------------------
  // Frame position
  // ----------------------------------------
  // sync seen before a rising edge starts the MSB
  always_comb
  begin
    if (ctrl_master)
      next_pos = (pos == frame_last) ? 8'h00 : pos + 8'h01;
    else if (sync_cap)
      next_pos = pcmsf_pkg::SLOT_FIRST;
    else if (pos == 8'h00 || pos >= pcmsf_pkg::SLOT_LAST)
      // Park; position zero is only a leftover of master role
      next_pos = 8'hFF;
    else
      next_pos = pos + 8'h01;
  end

  // Position advances on each rising edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pos <= 8'hFF;
    else if (!ctrl_en)
      pos <= 8'hFF;
    else if (rise_ev)
      pos <= next_pos;
  end

  // Slave side: frame sync is sampled on falling edges
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sync_cap <= 1'b0;
    else if (!ctrl_en || ctrl_master)
      sync_cap <= 1'b0;
    else if (fall_ev)
      sync_cap <= fsync_lvl;
  end

  // master sync lasts exactly one bit period
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fsync_out <= 1'b0;
    else if (!ctrl_en || !ctrl_master || leave_master)
      // Drop with the role write so no sync stands in slave role
      fsync_out <= 1'b0;
    else if (rise_ev)
      fsync_out <= (next_pos == 8'h00);
  end

  // ----------------------------------------
  // Transmit path
  // ----------------------------------------
  // data launched on rising edge, MSB first
  // output held low outside the slot
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dout <= 1'b0;
      tx_word <= '0;
    end
    else if (!ctrl_en)
      dout <= 1'b0;
    else if (rise_ev)
    begin
      if (next_pos == pcmsf_pkg::SLOT_FIRST)
      begin
        tx_word <= {tx_data[14:0], 1'b0};
        dout <= tx_data[15];
      end
      else if (next_pos > pcmsf_pkg::SLOT_FIRST && next_pos <= pcmsf_pkg::SLOT_LAST)
      begin
        tx_word <= {tx_word[14:0], 1'b0};
        dout <= tx_word[15];
      end
      else
        dout <= 1'b0;
    end
  end

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  // data captured on falling edge
  // sixteen linear bits, shifted in, stored whole at slot end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_shift <= '0;
      rx_data <= '0;
    end
    else if (fall_ev && pos >= pcmsf_pkg::SLOT_FIRST && pos <= pcmsf_pkg::SLOT_LAST)
    begin
      rx_shift <= {rx_shift[14:0], din_lvl};
      if (pos == pcmsf_pkg::SLOT_LAST)
        rx_data <= {rx_shift[14:0], din_lvl};
    end
  end

  // Status flags: a hardware set wins over a software clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_valid <= 1'b0;
      overrun <= 1'b0;
      tx_empty <= 1'b1;
    end
    else
    begin
      if (fall_ev && pos == pcmsf_pkg::SLOT_LAST)
      begin
        rx_valid <= 1'b1;
        if (rx_valid && !rd_rx)
          overrun <= 1'b1;
      end
      else if (rd_rx)
        rx_valid <= 1'b0;
      if (rise_ev && next_pos == pcmsf_pkg::SLOT_FIRST)
        tx_empty <= 1'b1;
      else if (wr_tx)
        tx_empty <= 1'b0;
      // Overrun clears on a status read
      if (rd_stat && !(fall_ev && pos == pcmsf_pkg::SLOT_LAST))
        overrun <= 1'b0;
    end
  end

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  assign acc = hsel && hready && htrans[1];
  assign leave_master = wr_pend && (wr_addr == pcmsf_pkg::OFS_CTRL)
    && !(hwdata[pcmsf_pkg::CTRL_EN_BIT] && hwdata[pcmsf_pkg::CTRL_MASTER_BIT]);
  assign addr_ok = (haddr == pcmsf_pkg::OFS_CTRL) || (haddr == pcmsf_pkg::OFS_STATUS)
    || (haddr == pcmsf_pkg::OFS_TXDATA) || (haddr == pcmsf_pkg::OFS_RXDATA);
  assign rd_rx = acc && !hwrite && (haddr == pcmsf_pkg::OFS_RXDATA);
  assign rd_stat = acc && !hwrite && (haddr == pcmsf_pkg::OFS_STATUS);
  assign wr_tx = wr_pend && (wr_addr == pcmsf_pkg::OFS_TXDATA);

  // Read data chosen in address phase; unmapped reads give zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (haddr)
      pcmsf_pkg::OFS_CTRL:
        next_rdata = {27'h0, ctrl_rate, ctrl_master, ctrl_en};
      pcmsf_pkg::OFS_STATUS:
        next_rdata = {29'h0, overrun, tx_empty, rx_valid};
      pcmsf_pkg::OFS_TXDATA:
        next_rdata = {16'h0, tx_data};
      pcmsf_pkg::OFS_RXDATA:
        next_rdata = {16'h0, rx_data};
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= acc && hwrite && addr_ok;
      if (acc)
        wr_addr <= haddr;
      if (acc && !hwrite)
        hrdata <= next_rdata;
    end
  end

  // role and rate written by software
  // reset gives master at 2048k with 8k frames
  // no frame-format field: short frame only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_en <= pcmsf_pkg::CTRL_EN_RST;
      ctrl_master <= pcmsf_pkg::CTRL_MASTER_RST;
      ctrl_rate <= pcmsf_pkg::CTRL_RATE_RST;
      tx_data <= '0;
    end
    else if (wr_pend)
    begin
      if (wr_addr == pcmsf_pkg::OFS_CTRL)
      begin
        ctrl_en <= hwdata[pcmsf_pkg::CTRL_EN_BIT];
        ctrl_master <= hwdata[pcmsf_pkg::CTRL_MASTER_BIT];
        // Unknown codes fall back to the default rate
        if (hwdata[pcmsf_pkg::CTRL_RATE_LSB+:3] > 3'h4)
          ctrl_rate <= pcmsf_pkg::CTRL_RATE_RST;
        else
          ctrl_rate <= pcmsf_pkg::pcmsf_rate_t'(hwdata[pcmsf_pkg::CTRL_RATE_LSB+:3]);
      end
      if (wr_addr == pcmsf_pkg::OFS_TXDATA)
        tx_data <= hwdata[15:0];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_slot_start;
    rise_ev && next_pos == pcmsf_pkg::SLOT_FIRST && ctrl_en;
  endsequence

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("Bus slave not ready or error");
  a_dout_idle: assert property (dout |-> (pos >= 8'h01 && pos <= 8'h10))
    else $error("Data driven outside slot");
  a_sync_pos: assert property (fsync_out |-> pos == 8'h00 && ctrl_master)
    else $error("Sync outside position zero");
  a_pin_role: assert property (!ctrl_master |-> !bclk_oe && !fsync_oe && !fsync_out)
    else $error("Slave drives clock or sync");
  a_msb_first: assert property (s_slot_start |=> dout == $past(tx_data[15]))
    else $error("First slot bit is not MSB");
  a_launch_rise: assert property ($changed(dout) && ctrl_en |-> $past(rise_ev))
    else $error("Data changed off rising edge");
  a_rx_word: assert property (fall_ev && pos == 8'h10 |=> rx_valid
    && rx_data[0] == $past(din_lvl))
    else $error("Sample not stored at slot end");
  a_frame_wrap: assert property (ctrl_en && ctrl_master && rise_ev && pos == frame_last
    |=> pos == 8'h00 ##0 fsync_out)
    else $error("Master frame length wrong");
  a_rate_reset: assert property ($rose(hresetn) |-> ctrl_master
    && ctrl_rate == pcmsf_pkg::PCMSF_R2048K)
    else $error("Reset role or rate wrong");

endmodule : pcmsf_port

// ===== core/pcmsf_pkg.sv
// Constants for the short-frame PCM audio port.
// Assumes a 100 MHz system clock and an AHB-Lite register bus.
package pcmsf_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  // System clock rate in Hz
  localparam longint CLK_HZ = 100_000_000;
  // Phase accumulator width of the bit-clock generator
  localparam int NCO_W = 24;
  // Bit clock rates in Hz, as the codec expects them
  localparam longint BCLK_256K_HZ = 256_000;
  localparam longint BCLK_512K_HZ = 512_000;
  localparam longint BCLK_1024K_HZ = 1_024_000;
  localparam longint BCLK_2048K_HZ = 2_048_000;
  localparam longint BCLK_4069K_HZ = 4_069_000;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0C;

  // CTRL fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MASTER_BIT = 1;
  localparam int CTRL_RATE_LSB = 2;
  // STATUS fields
  localparam int STAT_RXV_BIT = 0;
  localparam int STAT_TXE_BIT = 1;
  localparam int STAT_OVR_BIT = 2;

  // Sample width and slot layout
  localparam int SAMPLE_W = 16;
  localparam logic [7:0] SLOT_FIRST = 8'h01;
  localparam logic [7:0] SLOT_LAST = 8'h10;

  // Rate selections
  typedef enum logic [2:0] {
    PCMSF_R256K = 3'h0,
    PCMSF_R512K = 3'h1,
    PCMSF_R1024K = 3'h2,
    PCMSF_R2048K = 3'h3,
    PCMSF_R4069K = 3'h4
  } pcmsf_rate_t;

  // Reset values
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic CTRL_MASTER_RST = 1'b1;
  localparam pcmsf_rate_t CTRL_RATE_RST = PCMSF_R2048K;

endpackage : pcmsf_pkg

// ===== verif/pcmsf_codec_model.sv
// Behavioural audio codec that sits on the far side of the PCM port.
// Assumes the bench resolves the clock and sync pins from both output enables.
`timescale 1ns/100ps
module pcmsf_codec_model
(
  // Resolved link pins
  input wire logic bclk,
  input wire logic fsync,
  input wire logic dout,
  // Bench control: make clock and sync, word to send
  input wire logic gen,
  input wire logic [15:0] tx_word,
  // Codec as timing master
  output logic bclk_gen,
  output logic fsync_gen,
  // Codec data and what it heard
  output logic din,
  output logic [15:0] rx_word,
  output logic [7:0] rx_cnt,
  output logic [7:0] idle_bad
);
  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  logic sync_seen; // Sync high at the last falling edge
  int pos; // Slot position, 17 means idle
  logic [15:0] shift; // Incoming bits, MSB first

  // one-period sync, 32 clocks a frame
  initial
  begin
    bclk_gen = 1'b0;
    fsync_gen = 1'b0;
    din = 1'b0;
    rx_word = 16'h0000;
    rx_cnt = 8'h00;
    idle_bad = 8'h00;
    sync_seen = 1'b0;
    pos = 17;
    shift = 16'h0000;
    // Odd offset keeps the link clock out of phase with hclk
    #3;
    forever
    begin
      // Clock stands still while the bench does not ask for it
      if (gen)
        for (int i = 0; i < 32; i++)
        begin
          fsync_gen = (i == 0);
          bclk_gen = 1'b1;
          #80 bclk_gen = 1'b0;
          #80;
        end
      else
        #10;
    end
  end

  // launch MSB first on rising edges
  always @(posedge bclk)
  begin
    pos = sync_seen ? 1 : ((pos < 17) ? pos + 1 : 17);
    sync_seen = 1'b0;
    // Outside the slot the line toggles so stale data cannot pass
    din = (pos <= 16) ? tx_word[16 - pos] : ~din;
  end

  // capture on falling edges, idle data low
  always @(negedge bclk)
  begin
    if (fsync === 1'b1)
      sync_seen = 1'b1;
    if (pos <= 16)
      shift = {shift[14:0], dout};
    else if (dout !== 1'b0)
      idle_bad = idle_bad + 8'h01;
    if (pos == 16)
    begin
      rx_word = shift;
      rx_cnt = rx_cnt + 8'h01;
    end
  end
endmodule : pcmsf_codec_model

// ===== verif/pcmsf_port_tb.sv
// Self-checking bench for the PCM port: bus, clock rates, roles, data.
// Assumes the codec model in its own file and the port package.
`timescale 1ns/100ps
module pcmsf_port_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic bclk, fsync, bclk_out, bclk_oe, fsync_out, fsync_oe, din, dout;
  logic bclk_gen, fsync_gen, gen;
  logic [15:0] codec_word, codec_heard;
  logic [7:0] rx_cnt, idle_bad;
  int fails = 0;
  int n_compared = 0;
  int n;
  realtime t0;
  // One row: rate code, bit clock in Hz, frame length or 0 to skip
  typedef struct {logic [2:0] code; longint hz; int flen;} pcmsf_row_t;
  pcmsf_row_t rows [5] = '{
    '{pcmsf_pkg::PCMSF_R256K, pcmsf_pkg::BCLK_256K_HZ, 0},
    '{pcmsf_pkg::PCMSF_R512K, pcmsf_pkg::BCLK_512K_HZ, 0},
    '{pcmsf_pkg::PCMSF_R1024K, pcmsf_pkg::BCLK_1024K_HZ, 0},
    '{pcmsf_pkg::PCMSF_R2048K, pcmsf_pkg::BCLK_2048K_HZ, 256},
    '{pcmsf_pkg::PCMSF_R4069K, pcmsf_pkg::BCLK_4069K_HZ, 256}};

  always #5 hclk = ~hclk;
  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  // Pin level follows whoever has its enable up
  assign bclk = bclk_oe ? bclk_out : bclk_gen;
  assign fsync = fsync_oe ? fsync_out : fsync_gen;

  pcmsf_port pcmsf_port_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bclk_in(bclk),
    .bclk_out(bclk_out), .bclk_oe(bclk_oe), .fsync_in(fsync), .fsync_out(fsync_out),
    .fsync_oe(fsync_oe), .din(din), .dout(dout));

  pcmsf_codec_model pcmsf_codec_model_inst (.bclk(bclk), .fsync(fsync), .dout(dout),
    .gen(gen), .tx_word(codec_word), .bclk_gen(bclk_gen), .fsync_gen(fsync_gen),
    .din(din), .rx_word(codec_heard), .rx_cnt(rx_cnt), .idle_bad(idle_bad));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One single AHB-Lite transfer; waits on ready, never on a fixed count
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // Waits until the codec has heard k more whole samples
  task automatic frames(input int k);
    logic [7:0] c;
    c = rx_cnt;
    wait (rx_cnt == c + 8'(k));
    // Let the synchronised edge land, and realign to hclk for the bus
    repeat (4) @(posedge hclk);
  endtask : frames

  // Bit clocks from one sync to the next
  task automatic frame_len(output int m);
    m = 0;
    // Look after the edge so the sync launched with it has settled
    do
    begin
      @(posedge bclk);
      #1;
    end
    while (fsync !== 1'b1);
    do
    begin
      @(posedge bclk);
      #1 m++;
    end
    while (fsync !== 1'b1 && m < 300);
    @(posedge hclk);
  endtask : frame_len

  // Sample both ways through three frames after the write
  task automatic xfer(input logic [15:0] tx, input logic [15:0] rx);
    logic [7:0] b;
    codec_word <= rx;
    ahb(1'b1, pcmsf_pkg::OFS_TXDATA, {16'h0000, tx});
    b = idle_bad;
    frames(3);
    check("codec heard", {16'h0000, codec_heard}, {16'h0000, tx});
    check("idle data", {24'h000000, idle_bad}, {24'h000000, b});
    ahb(1'b0, pcmsf_pkg::OFS_STATUS, 32'h00000000);
    check("rx valid", rd[pcmsf_pkg::STAT_RXV_BIT], 1'b1);
    check("tx empty", rd[pcmsf_pkg::STAT_TXE_BIT], 1'b1);
    check("overrun", rd[pcmsf_pkg::STAT_OVR_BIT], 1'b1);
    ahb(1'b0, pcmsf_pkg::OFS_RXDATA, 32'h00000000);
    check("rxdata", rd, {16'h0000, rx});
    ahb(1'b0, pcmsf_pkg::OFS_STATUS, 32'h00000000);
    check("status cleared", rd, 32'h00000001 << pcmsf_pkg::STAT_TXE_BIT);
  endtask : xfer

  task automatic conclude();
    $display("Compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    gen = 1'b0;
    codec_word = 16'h0000;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, pcmsf_pkg::OFS_CTRL, 32'h00000000);
    check("ctrl reset", rd, 32'h0000000F);
    ahb(1'b0, 8'h10, 32'h00000000);
    check("unmapped", rd, 32'h00000000);
    // Master role at the default rate
    xfer(16'hA53C, 16'h3CA5);
    // Every rate code: mean period over eight bit clocks
    foreach (rows[i])
    begin
      ahb(1'b1, pcmsf_pkg::OFS_CTRL, (32'(rows[i].code) << pcmsf_pkg::CTRL_RATE_LSB) | 32'h3);
      repeat (3) @(posedge bclk);
      t0 = $realtime;
      repeat (8) @(posedge bclk);
      check("bclk period", ($realtime - t0 - 8.0e9 / rows[i].hz) ** 2 < 625.0, 1'b1);
      if (rows[i].flen != 0)
      begin
        frame_len(n);
        check("frame length", n, rows[i].flen);
      end
    end
    // Slave role: the codec makes clock and sync
    ahb(1'b1, pcmsf_pkg::OFS_CTRL, 32'h0000000D);
    gen <= 1'b1;
    @(posedge hclk);
    check("clock enable", bclk_oe, 1'b0);
    check("sync enable", fsync_oe, 1'b0);
    xfer(16'h8001, 16'h7FFE);
    gen <= 1'b0;
    // Second reset in mid-run restores master defaults
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, pcmsf_pkg::OFS_CTRL, 32'h00000000);
    check("ctrl re-reset", rd, 32'h0000000F);
    check("clock enable", bclk_oe, 1'b1);
    conclude();
  end

  // Run needs under 0.75 ms; 0.95 ms keeps a hang under 100k cycles
  initial
  begin
    #950_000;
    fails++;
    conclude();
  end
endmodule : pcmsf_port_tb
